// *** rtl/timer_pkg.sv ***
// constants, field layouts and state types of the dual timer/counter
// assumes one clock (aclk) that also serves as the oscillator clock
package timer_pkg;
  localparam int UNITS = 2;
  localparam int MODE_NIBBLE = 4;
  // register byte addresses
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CLKCFG = 8'h08;
  localparam logic [7:0] OFS_COUNT0 = 8'h0c;
  localparam logic [7:0] OFS_COUNT1 = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // control_register fields
  localparam int CTRL_RUN0_BIT = 4;
  localparam int CTRL_OVF0_BIT = 5;
  localparam int CTRL_RUN1_BIT = 6;
  localparam int CTRL_OVF1_BIT = 7;
  // clock_config_register fields
  localparam int CK_DBL0_BIT = 0;
  localparam int CK_DBL1_BIT = 1;
  localparam int CK_X2_BIT = 2;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] CLKCFG_RST = 3'h0;
  localparam logic [1:0] RUN_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  // timing: six timer clocks per peripheral cycle
  localparam logic [2:0] PER_DIV_LAST = 3'h5;
  localparam logic [4:0] PRESCALE_LAST = 5'h1f;
  localparam logic [7:0] BYTE_LAST = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } unit_mode_type;

  // same order as one nibble of mode_register
  typedef struct packed {
    logic pin_qualify_enable;
    logic ext_count;
    unit_mode_type mode;
  } unit_cfg_type;

  typedef struct packed {
    logic [2:0] div;
    logic tick;
    logic sample;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic ovf;
  } unit_state_type;

  typedef enum logic {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } wr_state_type;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_type;

  typedef struct packed {
    logic half;
    logic [7:0] mode_register;
    logic [1:0] run_control_bit;
    logic [1:0] overflow_flag;
    logic [2:0] clock_config_register;
    logic [1:0] irq_mask;
    logic irq;
    wr_state_type wr_state;
    logic have_aw;
    logic have_w;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    rd_state_type rd_state;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } top_state_type;
endpackage

// *** rtl/timer_unit.sv ***
// one timer/counter unit: peripheral-cycle divider, edge sampler, 13/16-bit count
// assumes pins synchronous to aclk and loads only while the unit is stopped
`timescale 1ns/1ps
module timer_unit
  import timer_pkg::*;
(
  // clocking
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_half_tick,
  input wire logic double_speed_mode,
  input wire logic clock_double_select,
  // control
  input wire unit_cfg_type cfg,
  input wire logic run_control_bit,
  input wire logic external_qualify_pin,
  input wire logic count_pin,
  // preset
  input wire logic load_low,
  input wire logic load_high,
  input wire logic [15:0] load_value,
  // state
  output logic [15:0] count,
  output logic per_tick,
  output logic overflow
);
  unit_state_type st_r;
  unit_state_type st_nxt;
  logic tclk_en;
  logic step;
  logic enable;
  logic [16:0] sum16;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.ovf = 1'b0;
    step = 1'b0;
    sum16 = {1'b0, st_r.count_high_byte, st_r.count_low_byte} + 17'h00001;
    tclk_en = clock_double_select ? osc_half_tick : (double_speed_mode | osc_half_tick); // [RQ10]
    if (tclk_en)
    begin
      if (st_r.div == PER_DIV_LAST)
      begin
        st_nxt.div = 3'h0;
        st_nxt.tick = 1'b1; // [RQ7]
      end
      else
      begin
        st_nxt.div = st_r.div + 3'h1;
      end
    end
    enable = run_control_bit & (~cfg.pin_qualify_enable | external_qualify_pin); // [RQ12] [RQ17]
    if (st_r.tick)
    begin
      st_nxt.sample = count_pin; // [RQ8]
      step = cfg.ext_count ? (st_r.sample & ~count_pin) : 1'b1; // [RQ6] [RQ8]
    end
    if (step & enable)
    begin
      case (cfg.mode)
        MODE_13BIT:
        begin
          // upper three low-byte bits are left as written
          st_nxt.count_low_byte[4:0] = st_r.count_low_byte[4:0] + 5'h01; // [RQ14]
          if (st_r.count_low_byte[4:0] == PRESCALE_LAST)
          begin
            st_nxt.count_high_byte = st_r.count_high_byte + 8'h01; // [RQ14]
            st_nxt.ovf = (st_r.count_high_byte == BYTE_LAST); // [RQ13]
          end
        end
        MODE_16BIT:
        begin
          st_nxt.count_high_byte = sum16[15:8]; // [RQ2] [RQ15]
          st_nxt.count_low_byte = sum16[7:0];
          st_nxt.ovf = sum16[16]; // [RQ2] [RQ13]
        end
        default:
        begin
          // reload and split modes are not built: the count holds
          st_nxt.ovf = 1'b0;
        end
      endcase
    end
    if (load_low)
    begin
      st_nxt.count_low_byte = load_value[7:0];
    end
    if (load_high)
    begin
      st_nxt.count_high_byte = load_value[15:8];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign count = {st_r.count_high_byte, st_r.count_low_byte};
  assign per_tick = st_r.tick;
  assign overflow = st_r.ovf;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_tick_spacing: assert property (per_tick |=> !per_tick [*5]) // [RQ7]
    else $error("peripheral cycle shorter than six timer clocks");
  a_edge_counts: assert property ((cfg.ext_count && cfg.mode == MODE_16BIT && enable && st_r.tick
      && st_r.sample && !count_pin && !load_low && !load_high && count != 16'hffff)
      |=> count == $past(count) + 16'h0001) // [RQ8]
    else $error("falling edge on count input not counted");
  a_prescale_carry: assert property ((cfg.mode == MODE_13BIT && step && enable
      && st_r.count_low_byte[4:0] == PRESCALE_LAST && !load_high)
      |=> st_r.count_high_byte == $past(st_r.count_high_byte) + 8'h01) // [RQ14]
    else $error("prescaler overflow did not advance high byte");
  a_wrap_overflow: assert property ((cfg.mode == MODE_16BIT && step && enable && count == 16'hffff
      && !load_low && !load_high) |=> overflow && count == 16'h0000) // [RQ2]
    else $error("16-bit wrap did not raise overflow");
endmodule

// *** rtl/dual_timer_counter.sv ***
// dual timer/counter with AXI4-Lite register slave and masked interrupt
// assumes aclk is the oscillator clock and all pins are synchronous to it
//
// Notes on behaviour
// RQ1: two independent units, timer or counter each
// RQ2: low byte carry feeds high; high sets flag
// RQ3: setting run leaves count values untouched
// RQ4: software stops unit before presetting counts
// RQ5: software stops unit before changing mode
// RQ6: source select: internal clock or count pin
// RQ7: timer advances once per six timer clocks
// RQ8: count pin sampled per cycle, falling edge counts
// RQ9: count pin levels held one full cycle
// RQ10: double-select picks osc/2, else speed mode
// RQ11: unit zero uses low nibble, control bits 0,1,4,5; here it has bits 4,5 only
// RQ12: run alone enables unless qualify enabled
// RQ13: rollover to zero sets overflow flag, interrupt
// RQ14: mode 0 is 5-bit prescaler plus high byte
// RQ15: mode 1 is cascaded 16-bit counter
// RQ16: interrupt vectoring clears unit overflow flag
// RQ17: qualified counting needs pin high and run
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module dual_timer_counter
  import timer_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // timer pins, bit per unit
  input wire logic [1:0] external_qualify_pin,
  input wire logic [1:0] count_pin,
  // interrupt
  input wire logic [1:0] vector_ack,
  output logic irq
);
  top_state_type st_r;
  top_state_type st_nxt;
  logic [15:0] unit_count [UNITS];
  logic [1:0] unit_tick;
  logic [1:0] unit_ovf;
  logic [1:0] load_low;
  logic [1:0] load_high;
  logic [1:0] ovf_clear;
  logic [1:0] clock_double;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;

  assign clock_double = {st_r.clock_config_register[CK_DBL1_BIT], st_r.clock_config_register[CK_DBL0_BIT]};

  // two identical units, each with its own nibble and control bits
  genvar u;
  generate
    for (u = 0; u < UNITS; u++)
    begin : g_unit
      timer_unit unit_i ( // [RQ1]
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_half_tick(st_r.half),
        .double_speed_mode(st_r.clock_config_register[CK_X2_BIT]),
        .clock_double_select(clock_double[u]),
        .cfg(unit_cfg_type'(st_r.mode_register[u*MODE_NIBBLE +: MODE_NIBBLE])), // [RQ11]
        .run_control_bit(st_r.run_control_bit[u]),
        .external_qualify_pin(external_qualify_pin[u]),
        .count_pin(count_pin[u]),
        .load_low(load_low[u]),
        .load_high(load_high[u]),
        .load_value(st_r.wdata[15:0]),
        .count(unit_count[u]),
        .per_tick(unit_tick[u]),
        .overflow(unit_ovf[u])
      );
    end
  endgenerate

  // read decode; unmapped or misaligned addresses answer slverr
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    case (araddr)
      OFS_MODE:
      begin
        rd_word = {24'h000000, st_r.mode_register};
      end
      OFS_CTRL:
      begin
        rd_word[CTRL_RUN0_BIT] = st_r.run_control_bit[0];
        rd_word[CTRL_OVF0_BIT] = st_r.overflow_flag[0];
        rd_word[CTRL_RUN1_BIT] = st_r.run_control_bit[1];
        rd_word[CTRL_OVF1_BIT] = st_r.overflow_flag[1];
      end
      OFS_CLKCFG:
      begin
        rd_word = {29'h00000000, st_r.clock_config_register};
      end
      OFS_COUNT0:
      begin
        rd_word = {16'h0000, unit_count[0]};
      end
      OFS_COUNT1:
      begin
        rd_word = {16'h0000, unit_count[1]};
      end
      OFS_IRQ_STATUS:
      begin
        rd_word = {30'h00000000, st_r.overflow_flag};
      end
      OFS_IRQ_MASK:
      begin
        rd_word = {30'h00000000, st_r.irq_mask};
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    load_low = 2'h0;
    load_high = 2'h0;
    ovf_clear = 2'h0;
    wr_hit = 1'b1;
    st_nxt.half = ~st_r.half;
    do_write = (st_r.wr_state == WR_COLLECT) && st_r.have_aw && st_r.have_w;

    // address and data are taken independently, in either order
    if (awvalid && st_r.awready)
    begin
      st_nxt.have_aw = 1'b1;
      st_nxt.waddr = awaddr;
    end
    if (wvalid && st_r.wready)
    begin
      st_nxt.have_w = 1'b1;
      st_nxt.wdata = wdata;
      st_nxt.wstrb = wstrb;
    end

    case (st_r.wr_state)
      WR_COLLECT:
      begin
        if (do_write)
        begin
          case (st_r.waddr)
            OFS_MODE:
            begin
              if (st_r.wstrb[0])
              begin
                st_nxt.mode_register = st_r.wdata[7:0];
              end
            end
            OFS_CTRL:
            begin
              // overflow bits here are read-only; counts are not touched
              if (st_r.wstrb[0])
              begin
                st_nxt.run_control_bit[0] = st_r.wdata[CTRL_RUN0_BIT]; // [RQ3] [RQ11]
                st_nxt.run_control_bit[1] = st_r.wdata[CTRL_RUN1_BIT]; // [RQ3]
              end
            end
            OFS_CLKCFG:
            begin
              if (st_r.wstrb[0])
              begin
                st_nxt.clock_config_register = st_r.wdata[2:0];
              end
            end
            OFS_COUNT0:
            begin
              load_low[0] = st_r.wstrb[0];
              load_high[0] = st_r.wstrb[1];
            end
            OFS_COUNT1:
            begin
              load_low[1] = st_r.wstrb[0];
              load_high[1] = st_r.wstrb[1];
            end
            OFS_IRQ_STATUS:
            begin
              if (st_r.wstrb[0])
              begin
                ovf_clear = st_r.wdata[1:0];
              end
            end
            OFS_IRQ_MASK:
            begin
              if (st_r.wstrb[0])
              begin
                st_nxt.irq_mask = st_r.wdata[1:0];
              end
            end
            default:
            begin
              wr_hit = 1'b0;
            end
          endcase
          st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
          st_nxt.bvalid = 1'b1;
          st_nxt.have_aw = 1'b0;
          st_nxt.have_w = 1'b0;
          st_nxt.wr_state = WR_RESP;
        end
      end
      WR_RESP:
      begin
        if (bready)
        begin
          st_nxt.bvalid = 1'b0;
          st_nxt.wr_state = WR_COLLECT;
        end
      end
      default:
      begin
        st_nxt.wr_state = WR_COLLECT;
      end
    endcase
    st_nxt.awready = (st_nxt.wr_state == WR_COLLECT) && !st_nxt.have_aw;
    st_nxt.wready = (st_nxt.wr_state == WR_COLLECT) && !st_nxt.have_w;

    case (st_r.rd_state)
      RD_IDLE:
      begin
        if (arvalid && st_r.arready)
        begin
          st_nxt.rdata = rd_word;
          st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
          st_nxt.rvalid = 1'b1;
          st_nxt.arready = 1'b0;
          st_nxt.rd_state = RD_DATA;
        end
      end
      RD_DATA:
      begin
        if (rready)
        begin
          st_nxt.rvalid = 1'b0;
          st_nxt.arready = 1'b1;
          st_nxt.rd_state = RD_IDLE;
        end
      end
      default:
      begin
        st_nxt.rd_state = RD_IDLE;
      end
    endcase

    // a rollover in the clearing cycle keeps the flag set
    st_nxt.overflow_flag = (st_r.overflow_flag & ~ovf_clear & ~vector_ack) | unit_ovf; // [RQ13] [RQ16]
    st_nxt.irq = |(st_nxt.overflow_flag & st_r.irq_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.mode_register <= MODE_RST;
      st_r.clock_config_register <= CLKCFG_RST;
      st_r.run_control_bit <= RUN_RST;
      st_r.irq_mask <= MASK_RST;
      st_r.wr_state <= WR_COLLECT;
      st_r.rd_state <= RD_IDLE;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rresp = st_r.rresp;
  assign rdata = st_r.rdata;
  assign irq = st_r.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_run_set0;
    $rose(st_r.run_control_bit[0]);
  endsequence

  sequence s_ack_only0;
    vector_ack[0] && !unit_ovf[0];
  endsequence

  // unit 1 shares the interrupt line, so only unit 0's own mask is looked at
  a_ovf_sets_flag: assert property (unit_ovf[0] |=> st_r.overflow_flag[0] && (irq || !$past(st_r.irq_mask[0]))) // [RQ13]
    else $error("overflow did not set flag and interrupt");
  a_ack_clears_flag: assert property (s_ack_only0 |=> !st_r.overflow_flag[0]) // [RQ16]
    else $error("vectoring did not clear overflow flag");
  a_run_keeps_count: assert property (s_run_set0 |-> unit_count[0] == $past(unit_count[0])) // [RQ3]
    else $error("starting the unit changed its count");
  a_stop_holds: assert property ((!st_r.run_control_bit[1] && !load_low[1] && !load_high[1])
      |=> $stable(unit_count[1])) // [RQ12]
    else $error("stopped unit kept counting");
  a_gate_low_holds: assert property ((st_r.mode_register[3] && !external_qualify_pin[0]
      && !load_low[0] && !load_high[0]) |=> $stable(unit_count[0])) // [RQ17]
    else $error("qualified unit counted with pin low");
  a_timer_rate: assert property ((unit_tick[0] && !st_r.clock_config_register[CK_X2_BIT]
      && $stable(st_r.clock_config_register))
      |=> (!unit_tick[0] || st_r.clock_config_register[CK_X2_BIT]) [*8]) // [RQ10]
    else $error("standard-speed timer clock too fast");
  a_write_answer: assert property ((do_write && st_r.waddr == OFS_MODE) |=> bvalid && bresp == RESP_OKAY) // [RQ11]
    else $error("write not answered in one cycle");
endmodule

// *** bench/pin_partner.sv ***
// pin partner: external event source that toggles the count pins
// assumes a one-cycle go with n and hold steady while busy
`timescale 1ns/1ps
module pin_partner
(
  // clocking
  input wire logic aclk,
  // command
  input wire logic go,
  input wire logic [3:0] n,
  input wire logic [5:0] hold,
  // pin side
  output logic pin,
  output logic busy
);
  logic [4:0] left;
  logic [5:0] cnt;

  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    left = 5'h00;
    cnt = 6'h00;
  end

  // starts high, odd number of toggles, so it ends low after n falling edges
  always @(posedge aclk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      pin <= 1'b1;
      left <= {n, 1'b0} - 5'h01;
      cnt <= hold - 6'h01;
    end
    else if (busy)
    begin
      // every level stays at least one peripheral cycle
      if (cnt != 6'h00)
        cnt <= cnt - 6'h01;
      else if (left != 5'h00)
      begin
        pin <= ~pin;
        left <= left - 5'h01;
        cnt <= hold - 6'h01;
      end
      else
        busy <= 1'b0;
    end
  end
endmodule

// *** bench/tb_dual_timer_counter.sv ***
// self-checking bench for the dual timer/counter
// assumes the AXI4-Lite map and timing given with timer_pkg
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module tb_dual_timer_counter;
  import timer_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, go, pin, busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, np;
  logic [1:0] bresp, rresp, qpin, vack, r;
  logic [2:0] ck;
  logic [15:0] pre;
  logic [7:0] offs [7];
  int miscompares, total_checks, cyc, k;

  dual_timer_counter DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .external_qualify_pin(qpin), .count_pin({2{pin}}), .vector_ack(vack), .irq);
  pin_partner PTR (.aclk, .go, .n(np), .hold(6'h0c), .pin, .busy);

  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  task final_report;
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      final_report;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad;
    logic dd;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      ad = ad | awready;
      dd = dd | wready;
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wok(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    `CHK("bresp", RESP_OKAY, rs)
  endtask

  task automatic rv(input logic [7:0] a, output logic [31:0] v);
    logic [1:0] rs;
    rd(a, v, rs);
    `CHK("rresp", RESP_OKAY, rs)
  endtask

  // aclk cycles per count step for a unit
  function automatic int per_of(input logic [2:0] c, input int u);
    return (c[u] || !c[CK_X2_BIT]) ? 12 : 6;
  endfunction

  // the free-running divider leaves one step of phase slack
  function automatic logic near(input logic [15:0] g, input int e);
    return (g >= 16'(e - 1)) && (g <= 16'(e + 1));
  endfunction

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h00;
    {awaddr, araddr, wdata, wstrb, np, qpin, vack} = 60'h0;
    miscompares = 0;
    total_checks = 0;
    cyc = 0;
    offs = '{OFS_MODE, OFS_CTRL, OFS_CLKCFG, OFS_COUNT0, OFS_COUNT1, OFS_IRQ_STATUS, OFS_IRQ_MASK};
    void'($urandom(32'h18d3));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i])
    begin
      rv(offs[i], d);
      `CHK("reset_value", 32'h0, d)
    end
    rd(8'h1c, d, r);
    `CHK("unmapped_rresp", RESP_SLVERR, r)
    `CHK("unmapped_rdata", 32'h0, d)
    wr(8'h1c, 32'hffffffff, r);
    `CHK("unmapped_bresp", RESP_SLVERR, r)
    // gated timer at each clock choice, window set by the qualify pin
    for (k = 0; k < 3; k++)
    begin
      ck = (k == 0) ? 3'h4 : ((k == 1) ? 3'h5 : 3'h0);
      pre = 16'($urandom_range(32'h7fff));
      wok(OFS_CTRL, 32'h0);
      wok(OFS_CLKCFG, 32'(ck));
      wok(OFS_MODE, 32'h9);
      wok(OFS_COUNT0, 32'(pre));
      rv(OFS_MODE, d);
      `CHK("mode_readback", 32'h9, d)
      wok(OFS_CTRL, 32'h10);
      repeat (30) @(posedge aclk);
      rv(OFS_COUNT0, d);
      `CHK("count_held", pre, d[15:0])
      qpin <= 2'h1;
      repeat (120) @(posedge aclk);
      qpin <= 2'h0;
      wok(OFS_CTRL, 32'h0);
      rv(OFS_COUNT0, d);
      `CHK("gated_rate", 1'b1, near(d[15:0] - pre, 120 / per_of(ck, 0)))
    end
    // rollover in 13-bit and 16-bit form, flag, mask and both clears
    wok(OFS_CLKCFG, 32'h4);
    wok(OFS_IRQ_MASK, 32'h1);
    for (k = 0; k < 2; k++)
    begin
      wok(OFS_MODE, 32'(k));
      wok(OFS_COUNT0, (k == 0) ? 32'hffbd : 32'hfffd);
      wok(OFS_CTRL, 32'h10);
      do rv(OFS_IRQ_STATUS, d); while (d[0] !== 1'b1);
      wok(OFS_CTRL, 32'h0);
      rv(OFS_CTRL, d);
      `CHK("ctrl_flag", 2'h2, d[5:4])
      `CHK("irq_on", 1'b1, irq)
      rv(OFS_COUNT0, d);
      `CHK("roll_high", 8'h00, d[15:8])
      `CHK("roll_low", 1'b1, d[4:0] < 5'h04)
      wok(OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge aclk);
      `CHK("irq_masked", 1'b0, irq)
      wok(OFS_IRQ_MASK, 32'h1);
      if (k == 0)
        wok(OFS_IRQ_STATUS, 32'h1);
      else
      begin
        vack <= 2'h1;
        @(posedge aclk);
        vack <= 2'h0;
      end
      repeat (2) @(posedge aclk);
      `CHK("irq_off", 1'b0, irq)
      rv(OFS_IRQ_STATUS, d);
      `CHK("flag_cleared", 32'h0, d)
    end
    // falling edges on unit 1 while unit 0 stays put
    wok(OFS_CLKCFG, 32'h0);
    wok(OFS_MODE, 32'h50);
    wok(OFS_COUNT1, 32'h0);
    wok(OFS_COUNT0, 32'h1234);
    wok(OFS_CTRL, 32'h40);
    np <= 4'($urandom_range(15, 1));
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (30) @(posedge aclk);
    wok(OFS_CTRL, 32'h0);
    rv(OFS_COUNT1, d);
    `CHK("edge_count", 16'(np), d[15:0])
    rv(OFS_COUNT0, d);
    `CHK("other_unit", 16'h1234, d[15:0])
    final_report;
  end
endmodule
